// ### hw/tfm_consts.svh
// register offsets, field positions and timing figures of the monitor block
`ifndef TFM_CONSTS_SVH
`define TFM_CONSTS_SVH
`define TFM_ADDR_TX_SEL    8'h19
`define TFM_ADDR_TX_SAMPLE 8'h1a
`define TFM_ADDR_RX_SEL    8'h1e
`define TFM_ADDR_RX_SAMPLE 8'h1f
`define TFM_ADDR_CNT_HIGH  8'h25
`define TFM_ADDR_PATH_LOW  8'h26
`define TFM_ADDR_SYNC_LOW  8'h27
`define TFM_SEL_RESET      8'h00
`define TFM_BYTE_ZERO      8'h00
`define TFM_CNT_ZERO       12'h000
`define TFM_CNT_ONE        12'h001
`define TFM_CNT_MAX        12'hfff
`define TFM_CHAN_MSB       4
`define TFM_CHAN_ONE       5'h01
`define TFM_LAST_BIT_IDX   3'h7
`define TFM_CLK_MHZ        100
`define TFM_LONG_PERIOD_MS 1000
`define TFM_SHORT_PERIOD_MS 42
`define TFM_MS_TO_CYC(ms)  ((ms) * 1000 * `TFM_CLK_MHZ)
`define TFM_TMR_ZERO       32'h0000_0000
`define TFM_TMR_ONE        32'h0000_0001
`endif

// ### hw/tfm_pkg.sv
// shared types of the frame error and channel monitor block
package tfm_pkg;
  typedef logic [11:0] tfm_count_t;
  typedef logic [7:0]  tfm_byte_t;
  typedef logic [4:0]  tfm_chan_t;
endpackage

// ### hw/tfm_ds0_mon.sv
// captures one selected 64 kbit/s channel into a byte register
`timescale 1ns/1ps
`include "tfm_consts.svh"
module tfm_ds0_mon (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              bit_stb_i,
  input  wire logic              bit_i,
  input  wire tfm_pkg::tfm_chan_t slot_i,
  input  wire logic [2:0]        bit_idx_i,
  input  wire tfm_pkg::tfm_chan_t sel_i,
  output tfm_pkg::tfm_byte_t     sample_o
);
  tfm_pkg::tfm_byte_t shift_reg;
  tfm_pkg::tfm_byte_t sample_reg;
  logic               hit;
  tfm_pkg::tfm_chan_t sel_chan;

  // the select field codes channel n as n-1, so field 5 picks channel 6;
  // codes above 23 name no channel and never match a slot
  assign sel_chan = sel_i + `TFM_CHAN_ONE; // [RULE8] [RULE9]
  assign hit      = bit_stb_i && (slot_i == sel_chan);

  // first bit of the slot enters first and ends up in bit 7
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= `TFM_BYTE_ZERO;
    end else if (hit) begin
      shift_reg <= {shift_reg[6:0], bit_i}; // [RULE11]
    end
  end

  // refresh only once the eighth bit is in, so a read never sees a torn byte
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_reg <= `TFM_BYTE_ZERO;
    end else if (hit && bit_idx_i == `TFM_LAST_BIT_IDX) begin
      sample_reg <= {shift_reg[6:0], bit_i}; // [RULE14] [RULE7]
    end
  end

  assign sample_o = sample_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_capture;
    hit && bit_idx_i == `TFM_LAST_BIT_IDX |=>
      sample_o == {$past(shift_reg[6:0]), $past(bit_i)};
  endproperty
  a_capture: assert property (p_capture) // [RULE11]
    else $error("channel sample not refreshed after eighth bit");

  property p_hold;
    !(hit && bit_idx_i == `TFM_LAST_BIT_IDX) |=> $stable(sample_o);
  endproperty
  a_hold: assert property (p_hold) // [RULE14]
    else $error("channel sample changed mid slot");

  c_capture: cover property (hit && bit_idx_i == `TFM_LAST_BIT_IDX);
endmodule

// ### hw/tfm_top.sv
// frame error counters and transmit/receive channel monitors of a t1 framer
// Functional notes
// [RULE1] path counter: d4 counts ft errors, fs too if enabled; esf counts crc6
// [RULE2] out-of-sync mode: second counter adds one per multiframe spent unsynced
// [RULE3] out-of-sync mode keeps counting while receive sync is lost
// [RULE4] f-bit mode: second counter counts ft errors in d4, fps errors in esf
// [RULE5] f-bit mode: second counter is frozen while receive sync is lost
// [RULE6] second counter is 12 bits: high nibble at 25, low byte at 27
// [RULE7] one transmit and one receive channel are monitored at once
// [RULE8] transmit select field picks the channel shown in transmit sample
// [RULE9] receive select field picks the channel shown in receive sample
// [RULE10] software writes select fields in binary, channel n coded as n-1
// [RULE11] sample bit 7 holds first bit of channel, bit 0 the last
// [RULE12] counters move to readable copies every second or every 42 ms
// [RULE13] counters saturate at all ones and never roll over
// [RULE14] channel sample refreshed once per frame after all eight bits
`timescale 1ns/1ps
`include "tfm_consts.svh"
module tfm_top #(
  parameter int unsigned LONG_PERIOD_CYC  =
    `TFM_MS_TO_CYC(`TFM_LONG_PERIOD_MS),
  parameter int unsigned SHORT_PERIOD_CYC =
    `TFM_MS_TO_CYC(`TFM_SHORT_PERIOD_MS)
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  // parallel control port
  input  wire logic [7:0]         addr_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  input  wire tfm_pkg::tfm_byte_t wdata_i,
  output tfm_pkg::tfm_byte_t      rdata_o,
  // configuration held elsewhere in the framer
  input  wire logic               framing_format_select_i,
  input  wire logic               count_fs_errors_select_i,
  input  wire logic               out_of_sync_count_select_i,
  input  wire logic               timer_period_select_i,
  // receive framer events
  input  wire logic               receive_sync_lost_i,
  input  wire logic               ft_err_i,
  input  wire logic               fs_err_i,
  input  wire logic               fps_err_i,
  input  wire logic               crc6_err_i,
  input  wire logic               rx_mf_stb_i,
  // receive and transmit channel bit streams, and the period pulse output
  input  wire logic               rx_bit_stb_i,
  input  wire logic               rx_bit_i,
  input  wire tfm_pkg::tfm_chan_t rx_slot_i,
  input  wire logic [2:0]         rx_bit_idx_i,
  input  wire logic               tx_bit_stb_i,
  input  wire logic               tx_bit_i,
  input  wire tfm_pkg::tfm_chan_t tx_slot_i,
  input  wire logic [2:0]         tx_bit_idx_i,
  output logic                    period_tick_o
);
  tfm_pkg::tfm_byte_t tx_monitor_select_control_reg;
  tfm_pkg::tfm_byte_t rx_monitor_select_control_reg;
  tfm_pkg::tfm_byte_t tx_channel_sample;
  tfm_pkg::tfm_byte_t rx_channel_sample;
  tfm_pkg::tfm_byte_t rdata_reg;
  tfm_pkg::tfm_byte_t rdata_next;
  tfm_pkg::tfm_count_t path_violation_counter_reg;
  tfm_pkg::tfm_count_t path_violation_counter_next;
  tfm_pkg::tfm_count_t sync_loss_or_fbit_counter_reg;
  tfm_pkg::tfm_count_t sync_loss_or_fbit_counter_next;
  tfm_pkg::tfm_count_t path_latched_reg;
  tfm_pkg::tfm_count_t sync_latched_reg;
  logic [31:0]         tmr_reg;
  logic [31:0]         tmr_last;
  logic                tick;
  logic                unsynced_mf_reg;
  logic                path_evt;
  logic                fbit_evt;
  logic                mos_evt;
  logic                sync_evt;

  // saturating step shared by both counters
  function automatic tfm_pkg::tfm_count_t sat_step(
    input tfm_pkg::tfm_count_t cnt,
    input logic                en
  );
    sat_step = cnt;
    if (en && cnt != `TFM_CNT_MAX) begin
      sat_step = cnt + `TFM_CNT_ONE; // [RULE13]
    end
  endfunction

  // next value of a counter: a new period restarts it with this cycle's event
  function automatic tfm_pkg::tfm_count_t cnt_next(
    input tfm_pkg::tfm_count_t cnt,
    input logic                en,
    input logic                restart
  );
    if (restart) begin
      cnt_next = en ? `TFM_CNT_ONE : `TFM_CNT_ZERO;
    end else begin
      cnt_next = sat_step(cnt, en);
    end
  endfunction

  // period timer; switching period mid-run takes effect at once, a count already past the new end wraps on the next edge
  assign tmr_last = timer_period_select_i ? SHORT_PERIOD_CYC - `TFM_TMR_ONE
                                          : LONG_PERIOD_CYC - `TFM_TMR_ONE;
  assign tick     = (tmr_reg >= tmr_last);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr_reg <= `TFM_TMR_ZERO;
    end else if (tick) begin
      tmr_reg <= `TFM_TMR_ZERO; // [RULE12]
    end else begin
      tmr_reg <= tmr_reg + `TFM_TMR_ONE;
    end
  end

  // path errors depend on framing; all of them stop while sync is lost
  always_comb begin
    if (framing_format_select_i) begin
      path_evt = crc6_err_i; // [RULE1]
    end else begin
      path_evt = ft_err_i || (count_fs_errors_select_i && fs_err_i); // [RULE1]
    end
    path_evt = path_evt && !receive_sync_lost_i;
  end

  // f-bit errors are masked during loss of sync, multiframe counts are not
  assign fbit_evt = (framing_format_select_i ? fps_err_i : ft_err_i) &&
                    !receive_sync_lost_i; // [RULE4] [RULE5]
  assign mos_evt  = rx_mf_stb_i &&
                    (unsynced_mf_reg || receive_sync_lost_i); // [RULE2] [RULE3]
  assign sync_evt = out_of_sync_count_select_i ? mos_evt : fbit_evt;

  // remembers a sync loss seen anywhere inside the current multiframe
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      unsynced_mf_reg <= 1'b0;
    end else if (rx_mf_stb_i) begin
      unsynced_mf_reg <= 1'b0;
    end else if (receive_sync_lost_i) begin
      unsynced_mf_reg <= 1'b1; // [RULE2]
    end
  end

  assign path_violation_counter_next =
    cnt_next(path_violation_counter_reg, path_evt, tick);
  assign sync_loss_or_fbit_counter_next =
    cnt_next(sync_loss_or_fbit_counter_reg, sync_evt, tick);

  // live counters
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      path_violation_counter_reg    <= `TFM_CNT_ZERO;
      sync_loss_or_fbit_counter_reg <= `TFM_CNT_ZERO;
    end else begin
      path_violation_counter_reg    <= path_violation_counter_next;
      sync_loss_or_fbit_counter_reg <= sync_loss_or_fbit_counter_next;
    end
  end

  // readable copies hold the previous period for a whole period
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      path_latched_reg <= `TFM_CNT_ZERO;
      sync_latched_reg <= `TFM_CNT_ZERO;
    end else if (tick) begin
      path_latched_reg <= path_violation_counter_reg; // [RULE12]
      sync_latched_reg <= sync_loss_or_fbit_counter_reg; // [RULE12]
    end
  end

  // writable select registers; all eight bits are kept for read-back
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_monitor_select_control_reg <= `TFM_SEL_RESET;
      rx_monitor_select_control_reg <= `TFM_SEL_RESET;
    end else if (wr_i) begin
      if (addr_i == `TFM_ADDR_TX_SEL) begin
        tx_monitor_select_control_reg <= wdata_i; // [RULE10]
      end
      if (addr_i == `TFM_ADDR_RX_SEL) begin
        rx_monitor_select_control_reg <= wdata_i; // [RULE10]
      end
    end
  end

  // the two channel monitors run independently of each other
  tfm_ds0_mon u_tx_mon (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .bit_stb_i (tx_bit_stb_i),
    .bit_i     (tx_bit_i),
    .slot_i    (tx_slot_i),
    .bit_idx_i (tx_bit_idx_i),
    .sel_i     (tx_monitor_select_control_reg[`TFM_CHAN_MSB:0]), // [RULE8]
    .sample_o  (tx_channel_sample)
  );

  tfm_ds0_mon u_rx_mon (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .bit_stb_i (rx_bit_stb_i),
    .bit_i     (rx_bit_i),
    .slot_i    (rx_slot_i),
    .bit_idx_i (rx_bit_idx_i),
    .sel_i     (rx_monitor_select_control_reg[`TFM_CHAN_MSB:0]), // [RULE9]
    .sample_o  (rx_channel_sample)
  );

  // read decode; unmapped offsets answer zero
  always_comb begin
    case (addr_i)
      `TFM_ADDR_TX_SEL:    rdata_next = tx_monitor_select_control_reg;
      `TFM_ADDR_TX_SAMPLE: rdata_next = tx_channel_sample; // [RULE8]
      `TFM_ADDR_RX_SEL:    rdata_next = rx_monitor_select_control_reg;
      `TFM_ADDR_RX_SAMPLE: rdata_next = rx_channel_sample; // [RULE9]
      `TFM_ADDR_CNT_HIGH:  rdata_next = {sync_latched_reg[11:8],
                                         path_latched_reg[11:8]}; // [RULE6]
      `TFM_ADDR_PATH_LOW:  rdata_next = path_latched_reg[7:0];
      `TFM_ADDR_SYNC_LOW:  rdata_next = sync_latched_reg[7:0]; // [RULE6]
      default:             rdata_next = `TFM_BYTE_ZERO;
    endcase
  end

  // read data is registered and holds until the next read
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= `TFM_BYTE_ZERO;
    end else if (rd_i) begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o       = rdata_reg;
  assign period_tick_o = tick;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_path_esf;
    framing_format_select_i && crc6_err_i && !receive_sync_lost_i && !tick &&
      path_violation_counter_reg != `TFM_CNT_MAX |=>
      path_violation_counter_reg == $past(path_violation_counter_reg) + 12'h001;
  endproperty
  a_path_esf: assert property (p_path_esf) // [RULE1]
    else $error("crc6 error not counted in esf");

  property p_path_fs_off;
    !framing_format_select_i && !count_fs_errors_select_i && fs_err_i &&
      !ft_err_i && !tick |=> $stable(path_violation_counter_reg);
  endproperty
  a_path_fs_off: assert property (p_path_fs_off) // [RULE1]
    else $error("fs error counted while disabled");

  property p_mos_count;
    out_of_sync_count_select_i && rx_mf_stb_i && receive_sync_lost_i &&
      !tick && sync_loss_or_fbit_counter_reg != `TFM_CNT_MAX |=>
      sync_loss_or_fbit_counter_reg ==
        $past(sync_loss_or_fbit_counter_reg) + 12'h001;
  endproperty
  a_mos_count: assert property (p_mos_count) // [RULE3]
    else $error("unsynced multiframe not counted");

  property p_mos_quiet;
    out_of_sync_count_select_i && !rx_mf_stb_i && !tick |=>
      $stable(sync_loss_or_fbit_counter_reg);
  endproperty
  a_mos_quiet: assert property (p_mos_quiet) // [RULE2]
    else $error("multiframe count moved off a boundary");

  property p_fbit_esf;
    !out_of_sync_count_select_i && framing_format_select_i && fps_err_i &&
      !receive_sync_lost_i && !tick &&
      sync_loss_or_fbit_counter_reg != `TFM_CNT_MAX |=>
      sync_loss_or_fbit_counter_reg ==
        $past(sync_loss_or_fbit_counter_reg) + 12'h001;
  endproperty
  a_fbit_esf: assert property (p_fbit_esf) // [RULE4]
    else $error("fps error not counted");

  property p_fbit_lost;
    !out_of_sync_count_select_i && receive_sync_lost_i && !tick |=>
      $stable(sync_loss_or_fbit_counter_reg);
  endproperty
  a_fbit_lost: assert property (p_fbit_lost) // [RULE5]
    else $error("f-bit count moved during sync loss");

  property p_latch;
    tick |=> path_latched_reg == $past(path_violation_counter_reg) &&
             sync_latched_reg == $past(sync_loss_or_fbit_counter_reg) &&
             path_violation_counter_reg <= `TFM_CNT_ONE;
  endproperty
  a_latch: assert property (p_latch) // [RULE12]
    else $error("counters not transferred at period end");

  property p_sat;
    path_violation_counter_reg == `TFM_CNT_MAX && !tick |=>
      path_violation_counter_reg == `TFM_CNT_MAX;
  endproperty
  a_sat: assert property (p_sat) // [RULE13]
    else $error("path counter rolled over");

  property p_read_high;
    rd_i && addr_i == `TFM_ADDR_CNT_HIGH |=>
      rdata_o == {$past(sync_latched_reg[11:8]), $past(path_latched_reg[11:8])};
  endproperty
  a_read_high: assert property (p_read_high) // [RULE6]
    else $error("shared high byte read wrong");

  c_tick:     cover property (tick);
  c_mos_inc:  cover property (mos_evt && out_of_sync_count_select_i);
  c_path_sat: cover property (path_violation_counter_reg == `TFM_CNT_MAX);
endmodule

// ### tb/tb_top.sv
// self-checking bench for the frame error counters and channel monitors
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned LONG_CYC  = 10000;
  localparam int unsigned SHORT_CYC = 50;
  logic               ref_clk_i = 1'b0;
  logic               rst_i     = 1'b1;
  logic [7:0]         addr_i    = 8'h00;
  logic               wr_i      = 1'b0;
  logic               rd_i      = 1'b0;
  tfm_pkg::tfm_byte_t wdata_i   = 8'h00;
  tfm_pkg::tfm_byte_t rdata_o;
  logic [3:0]         cfg       = 4'h0;
  logic               lost      = 1'b0;
  logic [4:0]         ev        = 5'h00;
  logic               tx_stb    = 1'b0;
  logic               tx_bit    = 1'b0;
  logic               rx_stb    = 1'b0;
  logic               rx_bit    = 1'b0;
  tfm_pkg::tfm_chan_t slot      = 5'h00;
  logic [2:0]         idx       = 3'h0;
  logic               period_tick_o;
  int                 n_fail    = 0;
  int                 n_checks  = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  // cfg = {timer period, fs errors, out-of-sync mode, esf}
  tfm_top #(.LONG_PERIOD_CYC(LONG_CYC), .SHORT_PERIOD_CYC(SHORT_CYC)) u_dut (
    .ref_clk_i                  (ref_clk_i),
    .rst_i                      (rst_i),
    .addr_i                     (addr_i),
    .wr_i                       (wr_i),
    .rd_i                       (rd_i),
    .wdata_i                    (wdata_i),
    .rdata_o                    (rdata_o),
    .framing_format_select_i    (cfg[0]),
    .count_fs_errors_select_i   (cfg[2]),
    .out_of_sync_count_select_i (cfg[1]),
    .timer_period_select_i      (cfg[3]),
    .receive_sync_lost_i        (lost),
    .ft_err_i                   (ev[4]),
    .fs_err_i                   (ev[3]),
    .fps_err_i                  (ev[2]),
    .crc6_err_i                 (ev[1]),
    .rx_mf_stb_i                (ev[0]),
    .rx_bit_stb_i               (rx_stb),
    .rx_bit_i                   (rx_bit),
    .rx_slot_i                  (slot),
    .rx_bit_idx_i               (idx),
    .tx_bit_stb_i               (tx_stb),
    .tx_bit_i                   (tx_bit),
    .tx_slot_i                  (slot),
    .tx_bit_idx_i               (idx),
    .period_tick_o              (period_tick_o)
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write strobe, held for exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) #1;
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(posedge ref_clk_i) #1;
    wr_i = 1'b0;
  endtask

  // read data is settled one edge after the strobe edge
  task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                      input string what);
    @(posedge ref_clk_i) #1;
    addr_i = a;
    rd_i = 1'b1;
    @(posedge ref_clk_i) #1;
    rd_i = 1'b0;
    chk(what, {24'h0, e}, {24'h0, rdata_o});
  endtask

  // bounded wait for the period pulse; a hang ends the run
  task automatic wait_tick(output int cyc);
    cyc = 0;
    do begin
      @(posedge ref_clk_i) #1;
      cyc++;
      if (cyc > 3 * LONG_CYC) begin
        n_fail++;
        $display("mismatch period tick expected pulse seen none");
        give_verdict();
      end
    end while (period_tick_o !== 1'b1);
  endtask

  // holding an event high for n edges counts as n events
  task automatic fire(input int k, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_i) #1;
      ev[k] = 1'b1;
    end
    @(posedge ref_clk_i) #1;
    ev = 5'h00;
  endtask

  // one clean period of events, then the latched copies are read back
  task automatic cnt_case(input logic [2:0] c, input logic ls,
                          input int n[5], input logic [11:0] ep,
                          input logic [11:0] es);
    int cy;
    cfg[2:0] = c;
    lost = ls;
    wait_tick(cy);
    for (int k = 0; k < 5; k++) fire(k, n[k]);
    wait_tick(cy);
    @(posedge ref_clk_i) #1;
    rchk(8'h25, {es[11:8], ep[11:8]}, "count high nibbles");
    rchk(8'h26, ep[7:0], "path count low");
    rchk(8'h27, es[7:0], "second count low");
    lost = 1'b0;
  endtask

  task automatic period_case(input logic sel, input int exp);
    int cy;
    cfg[3] = sel;
    wait_tick(cy);
    wait_tick(cy);
    wait_tick(cy);
    chk("period length", exp, cy);
  endtask

  // one full frame, both directions at once with distinct data per slot
  task automatic frame();
    logic [7:0] tb;
    logic [7:0] rb;
    for (int s = 1; s <= 24; s++) begin
      for (int i = 0; i < 8; i++) begin
        tb = {5'(s), 3'h5};
        rb = 8'hc0 ^ {3'h0, 5'(s)};
        @(posedge ref_clk_i) #1;
        slot = 5'(s);
        idx = 3'(i);
        tx_stb = 1'b1;
        rx_stb = 1'b1;
        tx_bit = tb[7 - i];
        rx_bit = rb[7 - i];
      end
    end
    @(posedge ref_clk_i) #1;
    tx_stb = 1'b0;
    rx_stb = 1'b0;
  endtask

  int ev_n[5] = '{2, 4, 1, 2, 3};
  int sat_n[5] = '{0, 0, 0, 0, 4100};

  initial begin
    repeat (3) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    // reset state and refused accesses
    rchk(8'h19, 8'h00, "tx select reset");
    rchk(8'h1e, 8'h00, "rx select reset");
    rchk(8'h1a, 8'h00, "tx sample reset");
    wr(8'h26, 8'haa);
    rchk(8'h26, 8'h00, "read-only path count");
    rchk(8'h40, 8'h00, "unmapped read");
    // channel 6 is coded 5, channel 15 is coded 14
    wr(8'h19, 8'h05);
    wr(8'h1e, 8'h0e);
    rchk(8'h19, 8'h05, "tx select");
    rchk(8'h1e, 8'h0e, "rx select");
    frame();
    rchk(8'h1a, 8'h35, "tx sample ch6");
    rchk(8'h1f, 8'hcf, "rx sample ch15");
    // counter modes in the short period
    cfg[3] = 1'b1;
    cnt_case(3'b000, 1'b0, ev_n, 12'h003, 12'h003);
    cnt_case(3'b100, 1'b0, ev_n, 12'h005, 12'h003);
    cnt_case(3'b101, 1'b0, ev_n, 12'h004, 12'h001);
    cnt_case(3'b011, 1'b0, ev_n, 12'h004, 12'h000);
    cnt_case(3'b011, 1'b1, ev_n, 12'h000, 12'h002);
    cnt_case(3'b000, 1'b1, ev_n, 12'h000, 12'h000);
    cnt_case(3'b110, 1'b1, ev_n, 12'h000, 12'h002);
    period_case(1'b1, SHORT_CYC);
    period_case(1'b0, LONG_CYC);
    // both counters pushed past full scale within one long period
    cnt_case(3'b000, 1'b0, sat_n, 12'hfff, 12'hfff);
    give_verdict();
  end
endmodule
